/* File: design/accel_interrupt_pin_logic.sv */
`timescale 1ns/1ns
// How it works
// - two separate interrupt pins, any function each
// - pins always driven push-pull, never floating
// - active-high pin signalling after reset
// - polarity bit makes both pins active low
// - function asserts pin only while armed
// - routing bit picks pin per function
// - data flags latch, clear by data reads
// - other flags clear on cause register read
// - all functions run together, pins shared
// - new-sample flag follows unread new data
// - watermark clears on a data read once count is below threshold
// - overrun sets on full buffer outside bypass, on replaced data in bypass; clears on read
module accel_interrupt_pin_logic #(
  parameter int CNT_W = 6,
  parameter int THR_W = 5
) (
  input wire logic clk,
  input wire logic reset,
  // register access port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  // detection events, one-cycle pulses
  input wire logic single_tap_evt,
  input wire logic double_tap_evt,
  input wire logic activity_evt,
  input wire logic inactivity_evt,
  input wire logic free_fall_evt,
  // data-related conditions
  input wire logic new_data_avail,
  input wire logic [CNT_W-1:0] fifo_count,
  input wire logic [THR_W-1:0] buffer_control_samples,
  input wire logic [1:0] buffer_control_mode,
  input wire logic fifo_full,
  input wire logic bypass_replace_evt,
  // interrupt pins
  output logic first_irq_pin,
  output logic first_irq_pin_oe,
  output logic second_irq_pin,
  output logic second_irq_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter checks

  if (CNT_W < THR_W) begin : g_chk_cnt
    $error("fifo count narrower than the sample threshold");
  end
  if (THR_W < 1) begin : g_chk_thr
    $error("sample threshold needs at least one bit");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // true for an address inside the data register range
  function automatic logic is_data_addr(input logic [7:0] a);
    is_data_addr = (a >= irq_pkg::ADDR_DATA_FIRST) && (a <= irq_pkg::ADDR_DATA_LAST);
  endfunction

  // level of one pin from flags, arming, route selection and polarity
  function automatic logic pin_level(input logic [7:0] f, input logic [7:0] arm,
                                     input logic [7:0] sel, input logic inv);
    pin_level = (|(f & arm & sel)) ^ inv;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] arming_q, arming_d; // interrupt_arming_reg
  logic [7:0] routing_q, routing_d; // interrupt_routing_reg
  logic [7:0] format_q, format_d; // output_format_reg
  logic [7:0] rd_data_q, rd_data_d; // read answer
  logic cause_rd; // cause register read this cycle
  logic data_rd; // data register read this cycle
  logic [7:0] flags; // latched flags

  assign cause_rd = reg_rd_en && (reg_addr == irq_pkg::ADDR_CAUSE);
  assign data_rd = reg_rd_en && is_data_addr(reg_addr);

  // write decode and read mux
  always_comb begin
    arming_d = arming_q;
    routing_d = routing_q;
    format_d = format_q;
    rd_data_d = rd_data_q;
    // writes
    if (reg_wr_en && reg_addr == irq_pkg::ADDR_ARMING) begin
      arming_d = reg_wr_data;
    end else if (reg_wr_en && reg_addr == irq_pkg::ADDR_ROUTING) begin
      routing_d = reg_wr_data;
    end else if (reg_wr_en && reg_addr == irq_pkg::ADDR_FORMAT) begin
      format_d = reg_wr_data;
    end
    // reads
    if (reg_rd_en) begin
      if (reg_addr == irq_pkg::ADDR_ARMING) begin
        rd_data_d = arming_q;
      end else if (reg_addr == irq_pkg::ADDR_ROUTING) begin
        rd_data_d = routing_q;
      end else if (reg_addr == irq_pkg::ADDR_CAUSE) begin
        rd_data_d = flags;
      end else if (reg_addr == irq_pkg::ADDR_FORMAT) begin
        rd_data_d = format_q;
      end else begin
        // unmapped here, answers zero
        rd_data_d = 8'h00;
      end
    end
  end

  // register stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arming_q <= irq_pkg::RESET_ARMING;
      routing_q <= irq_pkg::RESET_ROUTING;
      format_q <= irq_pkg::RESET_FORMAT;
      rd_data_q <= 8'h00;
    end else begin
      arming_q <= arming_d;
      routing_q <= routing_d;
      format_q <= format_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign reg_rd_data = rd_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // flag set and clear requests

  flag_if #(.W(8)) fl ();

  logic wm_cond; // watermark condition
  logic ovr_set; // overrun set source
  assign wm_cond = fifo_count >= CNT_W'(buffer_control_samples);

  // each source drives its own bit, so all run at once
  always_comb begin
    fl.set_req = 8'h00;
    fl.clr_req = 8'h00;
    // latched event flags clear on a cause read
    fl.set_req[irq_pkg::BIT_SINGLE_TAP] = single_tap_evt;
    fl.set_req[irq_pkg::BIT_DOUBLE_TAP] = double_tap_evt;
    fl.set_req[irq_pkg::BIT_ACTIVITY] = activity_evt;
    fl.set_req[irq_pkg::BIT_INACTIVITY] = inactivity_evt;
    fl.set_req[irq_pkg::BIT_FREE_FALL] = free_fall_evt;
    if (cause_rd) begin
      fl.clr_req = irq_pkg::CAUSE_CLEARED_MASK;
    end
    // new sample held while data remains unread
    fl.set_req[irq_pkg::BIT_NEW_SAMPLE] = new_data_avail;
    fl.clr_req[irq_pkg::BIT_NEW_SAMPLE] = data_rd && !new_data_avail;
    // watermark drops once reads bring count below threshold
    fl.set_req[irq_pkg::BIT_WATERMARK] = wm_cond;
    fl.clr_req[irq_pkg::BIT_WATERMARK] = data_rd && !wm_cond;
    // overrun: full buffer outside bypass, replaced data in bypass
    if (buffer_control_mode != irq_pkg::MODE_BYPASS) begin
      ovr_set = fifo_full;
    end else begin
      ovr_set = bypass_replace_evt;
    end
    fl.set_req[irq_pkg::BIT_OVERRUN] = ovr_set;
    fl.clr_req[irq_pkg::BIT_OVERRUN] = data_rd && !ovr_set;
  end

  irq_flag_bank #(.W(8)) u_flags (
    .clk(clk),
    .reset(reset),
    .fl(fl.bank)
  );

  assign flags = fl.flags;

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  logic pin1_q, pin1_d; // first pin level
  logic pin2_q, pin2_d; // second pin level
  logic oe_q; // push-pull drive enable
  logic inv; // active-low select

  assign inv = format_q[irq_pkg::BIT_POLARITY_LOW];

  // armed flags with route zero go to pin one, route one to pin two
  always_comb begin
    pin1_d = pin_level(flags, arming_q, ~routing_q, inv);
    pin2_d = pin_level(flags, arming_q, routing_q, inv);
  end

  // reset gives idle low with active-high signalling
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin1_q <= 1'b0;
      pin2_q <= 1'b0;
      oe_q <= 1'b1;
    end else begin
      pin1_q <= pin1_d;
      pin2_q <= pin2_d;
      oe_q <= 1'b1; // both levels driven, never released
    end
  end

  assign first_irq_pin = pin1_q;
  assign second_irq_pin = pin2_q;
  assign first_irq_pin_oe = oe_q;
  assign second_irq_pin_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_pins_driven: assert property (@(posedge clk) disable iff (reset)
    first_irq_pin_oe && second_irq_pin_oe)
    else $error("interrupt pin not driven");

  a_idle_low_high: assert property (@(posedge clk) disable iff (reset)
    (!inv && (flags & arming_q & ~routing_q) == 8'h00) |=> !first_irq_pin)
    else $error("first pin high with nothing pending");

  a_invert_low: assert property (@(posedge clk) disable iff (reset)
    (inv && (flags & arming_q & routing_q) != 8'h00) |=> !second_irq_pin)
    else $error("inverted second pin not low while pending");

  a_disarmed_quiet: assert property (@(posedge clk) disable iff (reset)
    (arming_q == 8'h00 && !inv) [*2] |-> !first_irq_pin && !second_irq_pin)
    else $error("pin active with all functions disarmed");

  a_route_second: assert property (@(posedge clk) disable iff (reset)
    (!inv && (flags & arming_q & routing_q) != 8'h00) |=> second_irq_pin)
    else $error("routed flag missing on second pin");

  a_route_first: assert property (@(posedge clk) disable iff (reset)
    (!inv && (flags & arming_q & ~routing_q) != 8'h00) |=> first_irq_pin)
    else $error("route zero flag missing on first pin");

  a_data_flag_hold: assert property (@(posedge clk) disable iff (reset)
    (flags[irq_pkg::BIT_NEW_SAMPLE] && !data_rd) |=> flags[irq_pkg::BIT_NEW_SAMPLE])
    else $error("new sample flag dropped without a data read");

  a_cause_clear: assert property (@(posedge clk) disable iff (reset)
    (cause_rd && !activity_evt) |=> !flags[irq_pkg::BIT_ACTIVITY])
    else $error("activity flag survived cause read");

  a_event_latch: assert property (@(posedge clk) disable iff (reset)
    (flags[irq_pkg::BIT_FREE_FALL] && !cause_rd) |=> flags[irq_pkg::BIT_FREE_FALL])
    else $error("free fall flag lost without cause read");

  a_new_sample_set: assert property (@(posedge clk) disable iff (reset)
    new_data_avail |=> flags[irq_pkg::BIT_NEW_SAMPLE])
    else $error("new sample flag not set");

  a_wmark_clear: assert property (@(posedge clk) disable iff (reset)
    (data_rd && !wm_cond) |=> !flags[irq_pkg::BIT_WATERMARK])
    else $error("watermark not cleared below threshold");

  a_overrun_full: assert property (@(posedge clk) disable iff (reset)
    (buffer_control_mode != irq_pkg::MODE_BYPASS && fifo_full)
    |=> flags[irq_pkg::BIT_OVERRUN])
    else $error("overrun not set on full buffer");

  a_pin_follows: assert property (@(posedge clk) disable iff (reset)
    ##1 first_irq_pin == ((|($past(flags) & $past(arming_q) & ~$past(routing_q)))
                          ^ $past(inv)))
    else $error("first pin not OR of armed routed flags");

endmodule

/* File: design/flag_if.sv */
`timescale 1ns/1ns
// set and clear requests toward the flag bank, and the latched flags back
interface flag_if #(parameter int W = 8);
  logic [W-1:0] set_req; // one-cycle or level set per flag
  logic [W-1:0] clr_req; // one-cycle clear per flag
  logic [W-1:0] flags; // latched flags
  modport ctrl (output set_req, output clr_req, input flags);
  modport bank (input set_req, input clr_req, output flags);
endinterface

/* File: design/irq_flag_bank.sv */
`timescale 1ns/1ns
// latched flag bank; a set in the same cycle as a clear wins
module irq_flag_bank #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset,
  flag_if.bank fl
);

  logic [W-1:0] flags_q; // latched flags
  logic [W-1:0] flags_d; // next flags

  // next value: keep unless cleared, then merge fresh sets
  always_comb begin
    flags_d = (flags_q & ~fl.clr_req) | fl.set_req;
  end

  // register the flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_q <= W'(irq_pkg::RESET_FLAGS);
    end else begin
      flags_q <= flags_d;
    end
  end

  assign fl.flags = flags_q;

endmodule

/* File: design/irq_pkg.sv */
package irq_pkg;

  // register offsets on the register access port
  localparam logic [7:0] ADDR_ARMING = 8'h2E;
  localparam logic [7:0] ADDR_ROUTING = 8'h2F;
  localparam logic [7:0] ADDR_CAUSE = 8'h30;
  localparam logic [7:0] ADDR_FORMAT = 8'h31;
  localparam logic [7:0] ADDR_DATA_FIRST = 8'h32;
  localparam logic [7:0] ADDR_DATA_LAST = 8'h37;

  // flag bit positions, shared by arming, routing and cause registers
  localparam int BIT_NEW_SAMPLE = 7;
  localparam int BIT_SINGLE_TAP = 6;
  localparam int BIT_DOUBLE_TAP = 5;
  localparam int BIT_ACTIVITY = 4;
  localparam int BIT_INACTIVITY = 3;
  localparam int BIT_FREE_FALL = 2;
  localparam int BIT_WATERMARK = 1;
  localparam int BIT_OVERRUN = 0;

  // flags cleared by a cause register read
  localparam logic [7:0] CAUSE_CLEARED_MASK = 8'h7C;

  // polarity-select field position in the output format register
  localparam int BIT_POLARITY_LOW = 5;

  // reset values
  localparam logic [7:0] RESET_ARMING = 8'h00;
  localparam logic [7:0] RESET_ROUTING = 8'h00;
  localparam logic [7:0] RESET_FORMAT = 8'h00;
  localparam logic [7:0] RESET_FLAGS = 8'h00;

  // buffer mode code that means bypass
  localparam logic [1:0] MODE_BYPASS = 2'h0;

endpackage

/* File: dv/accel_interrupt_pin_logic_tb.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// bench: host model on the register port, detection sources driven here
module accel_interrupt_pin_logic_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic reg_wr_en, reg_rd_en;
  logic [7:0] evt_v = 8'h00; // event pulses by flag bit
  logic new_data_avail = 1'b0;
  logic [5:0] fifo_count = 6'h00;
  logic [4:0] buffer_control_samples = 5'h05; // watermark threshold
  logic [1:0] buffer_control_mode = 2'h0;
  logic fifo_full = 1'b0;
  logic p1, p1_oe, p2, p2_oe;
  logic [7:0] exp_q[$]; // expected read answers, oldest first
  logic [7:0] ra[3] = '{8'h2E, 8'h2F, 8'h31}; // writable registers
  logic [7:0] rnd;
  logic [7:0] m;
  int error_cnt = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  accel_interrupt_pin_logic #(.CNT_W(6), .THR_W(5)) u_accel_interrupt_pin_logic (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .single_tap_evt(evt_v[6]), .double_tap_evt(evt_v[5]), .activity_evt(evt_v[4]),
    .inactivity_evt(evt_v[3]), .free_fall_evt(evt_v[2]), .new_data_avail(new_data_avail),
    .fifo_count(fifo_count), .buffer_control_samples(buffer_control_samples),
    .buffer_control_mode(buffer_control_mode), .fifo_full(fifo_full),
    .bypass_replace_evt(evt_v[0]), .first_irq_pin(p1), .first_irq_pin_oe(p1_oe),
    .second_irq_pin(p2), .second_irq_pin_oe(p2_oe));
  irq_host_model u_irq_host_model (
    .clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en));
  ////////////////////////////////////////////////////////////////////////////////
  // report one mismatch
  task automatic fail(input string s);
    error_cnt++;
    $display("wrong value at %0t: %s", $time, s);
  endtask
  // step to just after the next edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // queue the expected answer, then read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_irq_host_model.rd(a);
  endtask
  // pin levels after the flag and pin stages settle; enables always on
  task automatic pins(input logic e1, input logic e2);
    repeat (2) @(posedge clk);
    #2;
    total_checks++;
    if ({p1, p2, p1_oe, p2_oe} !== {e1, e2, 2'b11}) fail("pin level");
  endtask
  // one-cycle event pulse
  task automatic pulse(input logic [7:0] v);
    tick();
    evt_v = v;
    tick();
    evt_v = 8'h00;
  endtask
  // verdict and end of run
  task automatic tally_and_finish();
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // read monitor: answer is registered on the taking edge and checked 2 ns after it
  always @(posedge clk) begin
    if (reg_rd_en === 1'b1) begin
      #2;
      total_checks++;
      if (exp_q.size() == 0) fail("unexpected read");
      else if (reg_rd_data !== exp_q.pop_front()) fail("read data");
    end
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    fail("timeout");
    tally_and_finish();
  end
  // main sequence
  initial begin
    rnd = 8'($urandom(32'h2a5e));
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    foreach (ra[i]) rd(ra[i], 8'h00);
    rd(8'h30, 8'h00);
    pins(1'b0, 1'b0);
    // read-write registers with random data, then cleared
    foreach (ra[i]) begin
      rnd = 8'($urandom);
      u_irq_host_model.wr(ra[i], rnd);
      rd(ra[i], rnd);
      u_irq_host_model.wr(ra[i], 8'h00);
    end
    u_irq_host_model.wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    rd(8'h40, 8'h00);
    // each event function, pins alternating
    for (int b = 2; b <= 6; b++) begin
      m = 8'h01 << b;
      u_irq_host_model.wr(8'h2E, 8'h00);
      u_irq_host_model.wr(8'h2F, b[0] ? m : 8'h00);
      u_irq_host_model.wr(8'h2E, m);
      pulse(m);
      pins(!b[0], b[0]);
      rd(8'h30, m);
      pins(1'b0, 1'b0);
      rd(8'h30, 8'h00);
    end
    // unarmed function and polarity
    u_irq_host_model.wr(8'h2E, 8'h00);
    u_irq_host_model.wr(8'h2F, 8'h00);
    pulse(8'h10);
    pins(1'b0, 1'b0);
    rd(8'h30, 8'h10);
    u_irq_host_model.wr(8'h31, 8'h20);
    pins(1'b1, 1'b1);
    u_irq_host_model.wr(8'h2E, 8'h10);
    pulse(8'h10);
    pins(1'b0, 1'b1);
    rd(8'h30, 8'h10);
    // inverted pending flag routed to the second pin
    u_irq_host_model.wr(8'h2E, 8'h00);
    u_irq_host_model.wr(8'h2F, 8'h10);
    u_irq_host_model.wr(8'h2E, 8'h10);
    pulse(8'h10);
    pins(1'b1, 1'b0);
    rd(8'h30, 8'h10);
    u_irq_host_model.wr(8'h2F, 8'h00);
    u_irq_host_model.wr(8'h31, 8'h00);
    pins(1'b0, 1'b0);
    // data flags, all on the first pin
    u_irq_host_model.wr(8'h2E, 8'hFF);
    tick();
    new_data_avail = 1'b1;
    pins(1'b1, 1'b0);
    tick();
    new_data_avail = 1'b0;
    rd(8'h30, 8'h80);
    pins(1'b1, 1'b0);
    rd(8'h32, 8'h00);
    pins(1'b0, 1'b0);
    tick();
    fifo_count = 6'h04;
    pins(1'b0, 1'b0);
    tick();
    fifo_count = 6'h05;
    pins(1'b1, 1'b0);
    tick();
    fifo_count = 6'h04;
    rd(8'h37, 8'h00);
    pins(1'b0, 1'b0);
    tick();
    buffer_control_mode = 2'($urandom_range(3, 1));
    fifo_full = 1'b1;
    pins(1'b1, 1'b0);
    tick();
    fifo_full = 1'b0;
    pulse(8'h10);
    rd(8'h30, 8'h11);
    pins(1'b1, 1'b0);
    rd(8'h33, 8'h00);
    pins(1'b0, 1'b0);
    tick();
    buffer_control_mode = 2'h0;
    pulse(8'h01);
    rd(8'h30, 8'h01);
    rd(8'h34, 8'h00);
    pins(1'b0, 1'b0);
    // watermark at a random nonzero threshold
    tick();
    buffer_control_samples = 5'($urandom_range(31, 1));
    fifo_count = 6'(buffer_control_samples) - 6'h01;
    pins(1'b0, 1'b0);
    tick();
    fifo_count = 6'(buffer_control_samples);
    pins(1'b1, 1'b0);
    rd(8'h35, 8'h00);
    pins(1'b1, 1'b0);
    tick();
    fifo_count = fifo_count - 6'h01;
    rd(8'h36, 8'h00);
    pins(1'b0, 1'b0);
    tick();
    if (exp_q.size() != 0) fail("reads left unanswered");
    tally_and_finish();
  end
endmodule

/* File: dv/irq_host_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// host side of the register port, one request at a time
module irq_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en
);
  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end
  // one byte write, held over exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
    // released lines stop showing the old value
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask
  // one byte read; the answer is judged by the bench monitor
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clk);
    #1;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
  endtask
endmodule
